// file: hibernate_wake_sequencer.v
// Hibernation entry and wake sequencer of an always-on domain, defects included.
// Assumes supply comparator outputs and the rouse pin are asynchronous levels,
// and rst_n is the always-on power-on reset, untouched by a system reset.
`timescale 1ns/1ps
`include "hibernate_wake_sequencer_defs.vh"

module hibernate_wake_sequencer (
   // Clock and reset.
   input wire clk,
   input wire rst_n,
   // Register port.
   input wire [3:0] addr,
   input wire [31:0] wr_data,
   input wire wr_stb,
   input wire rd_stb,
   output reg [31:0] rd_data,
   // Pins and supply monitors.
   input wire rouse_pin,
   input wire supply_above_por,
   input wire supply_above_bor,
   output reg supply_off_output,
   output reg core_isolate
);

   ////////////////////////////////////////////////////////////////////////////////
   // Local constants.
   localparam [2:0] ST_ACTIVE = 3'd0; // Core running.
   localparam [2:0] ST_ENTRY = 3'd1; // Request taken, match window open.
   localparam [2:0] ST_PRE_OFF = 3'd2; // Isolated, lead time before supply-off.
   localparam [2:0] ST_OFF_WAIT = 3'd3; // Supply-off driven, waiting for decay.
   localparam [2:0] ST_HIBER = 3'd4; // Asleep, wake sources armed.
   localparam [2:0] ST_EXIT = 3'd5; // Supply returning.
   localparam integer DIV_LAST = `SLOW_DIV - 1; // Cut to the counter width where compared.
   localparam integer LEAD_LAST = `LEAD_CYC - 1; // Cut to the counter width where compared.
   localparam integer ENTRY_LAST = `ENTRY_TICKS - 1; // Cut to the counter width where compared.
   localparam integer STABLE_LAST = `SUPPLY_STABLE_TICKS - 1; // Cut to the counter width where compared.

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.
   reg [8:0] div_q; // Hibernate tick divider.
   reg tick_q; // One-cycle hibernate tick enable.
   reg [1:0] rouse_s_q; // Rouse pin synchroniser.
   reg [1:0] por_s_q; // Power-on comparator synchroniser.
   reg [1:0] bor_s_q; // Brown-out comparator synchroniser.
   reg [2:0] state_q; // Sequencer state.
   reg [8:0] lead_q; // Lead-time counter before supply-off.
   reg [1:0] tick_cnt_q; // Hibernate tick counter for entry and exit.
   reg dip_seen_q; // Supply dipped after a short rise.
   reg pin_wake_q; // Current wake came from the rouse pin.
   reg [5:0] ctl_q; // Writable control bits.
   reg [3:0] sts_q; // Sticky wake status.
   reg [31:0] match_q; // RTC match value.
   reg [31:0] rtc_q; // RTC count.
   wire rouse; // Synchronised rouse pin.
   wire por_ok; // Synchronised supply above power-on threshold.
   wire bor_ok; // Synchronised supply above brown-out threshold.
   wire rtc_hit; // RTC equals match on a tick.
   wire ctl_wr; // Control write, blocked while isolated.
   wire kept_on; // Core supply stays on during sleep.
   wire supply_gone; // Supply has fallen below the active threshold.
   wire rtc_wake; // Armed RTC wake.
   wire pin_wake; // Armed pin wake.
   reg set_match; // Status set requests this cycle.
   reg set_pin;
   reg set_irq;
   reg set_lost;

   ////////////////////////////////////////////////////////////////////////////////
   // Functions.
   // Builds the control register read value; isolation hides all but the sleep flag.
   function [31:0] ctl_read;
      input [5:0] bits;
      input iso;
      input req_busy;
      begin
         if (iso) begin
            ctl_read = `CTL_ISOLATED_VIEW;
         end else begin
            ctl_read = {26'h000_0000, bits[5:1], req_busy};
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers and the hibernate tick.
   // Two flops on every asynchronous input before any logic reads it.
   always @(posedge clk) begin
      if (!rst_n) begin
         rouse_s_q <= 2'b00;
         por_s_q <= 2'b00;
         bor_s_q <= 2'b00;
      end else begin
         rouse_s_q <= {rouse_s_q[0], rouse_pin};
         por_s_q <= {por_s_q[0], supply_above_por};
         bor_s_q <= {bor_s_q[0], supply_above_bor};
      end
   end

   assign rouse = rouse_s_q[1];
   assign por_ok = por_s_q[1];
   assign bor_ok = bor_s_q[1];

   // Divides the system clock to the 32.768 kHz tick enable.
   always @(posedge clk) begin
      if (!rst_n) begin
         div_q <= 9'h000;
         tick_q <= 1'b0;
      end else if (div_q == DIV_LAST[8:0]) begin
         div_q <= 9'h000;
         tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 9'h001;
         tick_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Wake sources.
   assign kept_on = ctl_q[`CTL_KEPT_ON];
   assign rtc_hit = tick_q && (rtc_q == match_q);
   assign rtc_wake = rtc_hit && ctl_q[`CTL_RTC_WAKE_EN];
   assign pin_wake = rouse && ctl_q[`CTL_PIN_WAKE_EN];
   // Brown-out detection, when on, ends the loss window earlier than power-on.
   assign supply_gone = ctl_q[`CTL_BOR_EN] ? !bor_ok : !por_ok;
   assign ctl_wr = wr_stb && (addr == `OFS_SLEEP_CTRL) && !core_isolate;

   // RTC count runs on the tick; software may load it.
   always @(posedge clk) begin
      if (!rst_n) begin
         rtc_q <= 32'h0000_0000;
         match_q <= 32'hffff_ffff;
      end else begin
         if (wr_stb && addr == `OFS_RTC_COUNT) begin
            rtc_q <= wr_data;
         end else if (tick_q) begin
            rtc_q <= rtc_q + 32'h0000_0001;
         end
         if (wr_stb && addr == `OFS_RTC_MATCH) begin
            match_q <= wr_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer.
   // Steps from request through isolation, supply-off, sleep and exit.
   always @(posedge clk) begin
      if (!rst_n) begin
         state_q <= ST_ACTIVE;
         lead_q <= 9'h000;
         tick_cnt_q <= 2'b00;
         dip_seen_q <= 1'b0;
         pin_wake_q <= 1'b0;
         supply_off_output <= 1'b0;
         core_isolate <= 1'b0;
      end else begin
         case (state_q)
            ST_ACTIVE: begin
               // A request is taken only with the slow oscillator running.
               if (ctl_wr && wr_data[`CTL_REQ] && wr_data[`CTL_OSC_EN]) begin
                  state_q <= ST_ENTRY;
                  tick_cnt_q <= 2'b00;
               end
            end
            ST_ENTRY: begin
               // A pin wake here comes before the loss window and cancels entry.
               if (pin_wake) begin
                  state_q <= ST_ACTIVE;
               end else if (tick_q) begin
                  if (tick_cnt_q == ENTRY_LAST[1:0]) begin
                     core_isolate <= 1'b1;
                     lead_q <= 9'h000;
                     if (kept_on) begin
                        supply_off_output <= 1'b1;
                        state_q <= ST_HIBER;
                     end else begin
                        state_q <= ST_PRE_OFF;
                     end
                  end else begin
                     tick_cnt_q <= tick_cnt_q + 2'b01;
                  end
               end
            end
            ST_PRE_OFF: begin
               // Wakes are ignored for the lead time before supply-off.
               if (lead_q == LEAD_LAST[8:0]) begin
                  supply_off_output <= 1'b1;
                  state_q <= ST_OFF_WAIT;
               end else begin
                  lead_q <= lead_q + 9'h001;
               end
            end
            ST_OFF_WAIT: begin
               // Wakes stay lost until the supply has decayed.
               if (supply_gone) begin
                  state_q <= ST_HIBER;
               end
            end
            ST_HIBER: begin
               if (pin_wake || rtc_wake) begin
                  pin_wake_q <= pin_wake;
                  supply_off_output <= 1'b0;
                  tick_cnt_q <= 2'b00;
                  dip_seen_q <= 1'b0;
                  state_q <= ST_EXIT;
               end
            end
            ST_EXIT: begin
               if (kept_on) begin
                  core_isolate <= 1'b0;
                  state_q <= ST_ACTIVE;
               end else if (!por_ok) begin
                  // A fall after one or two ticks above threshold loses the interrupt.
                  if (tick_cnt_q != 2'b00) begin
                     dip_seen_q <= 1'b1;
                  end
                  tick_cnt_q <= 2'b00;
               end else if (tick_q) begin
                  if (tick_cnt_q == STABLE_LAST[1:0]) begin
                     core_isolate <= 1'b0;
                     state_q <= ST_ACTIVE;
                  end else begin
                     tick_cnt_q <= tick_cnt_q + 2'b01;
                  end
               end
            end
            default: begin
               state_q <= ST_ACTIVE;
               supply_off_output <= 1'b0;
               core_isolate <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status events.
   // Decides which sticky status bits the hardware sets this cycle.
   always @* begin
      set_match = 1'b0;
      set_pin = 1'b0;
      set_irq = 1'b0;
      set_lost = 1'b0;
      case (state_q)
         ST_ACTIVE: begin
            set_match = rtc_hit;
            set_pin = rouse;
            set_irq = rouse;
         end
         ST_ENTRY: begin
            // Matches in the first ticks after the request vanish.
            set_lost = rtc_hit;
            set_pin = pin_wake;
            set_irq = pin_wake;
         end
         ST_PRE_OFF, ST_OFF_WAIT: begin
            set_lost = pin_wake || rtc_wake;
         end
         ST_HIBER: begin
            set_match = rtc_wake;
            set_pin = pin_wake;
         end
         ST_EXIT: begin
            // Rouse interrupt raised at completion of a pin wake unless a dip was seen.
            set_irq = pin_wake_q && !dip_seen_q &&
               (kept_on || (por_ok && tick_q && tick_cnt_q == STABLE_LAST[1:0]));
         end
         default: begin
            set_lost = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.
   // Control bits; the request bit self-clears, writes are blocked while isolated.
   always @(posedge clk) begin
      if (!rst_n) begin
         ctl_q <= `CTL_RESET;
      end else if (ctl_wr) begin
         ctl_q <= {wr_data[5:1], 1'b0};
      end
   end

   // Sticky status, write one to clear; a set in the same cycle wins.
   always @(posedge clk) begin
      if (!rst_n) begin
         sts_q <= `STS_RESET;
      end else begin
         if (wr_stb && addr == `OFS_WAKE_STATUS) begin
            sts_q <= (sts_q & ~wr_data[3:0]) | {set_lost, set_irq, set_pin, set_match};
         end else begin
            sts_q <= sts_q | {set_lost, set_irq, set_pin, set_match};
         end
      end
   end

   // Read data stand for the single cycle after the read strobe.
   always @(posedge clk) begin
      if (!rst_n) begin
         rd_data <= 32'h0000_0000;
      end else if (rd_stb) begin
         case (addr)
            `OFS_SLEEP_CTRL: begin
               rd_data <= ctl_read(ctl_q, core_isolate, state_q == ST_ENTRY);
            end
            `OFS_WAKE_STATUS: begin
               rd_data <= {21'h00_0000, state_q, 4'h0, sts_q};
            end
            `OFS_RTC_MATCH: begin
               rd_data <= match_q;
            end
            `OFS_RTC_COUNT: begin
               rd_data <= rtc_q;
            end
            default: begin
               rd_data <= 32'h0000_0000;
            end
         endcase
      end else begin
         rd_data <= 32'h0000_0000;
      end
   end

endmodule

// file: hibernate_wake_sequencer_defs.vh
// Constants for the hibernate wake sequencer: register offsets, field positions,
// reset values and timing counts.
// Assumes a 10 MHz system clock and a 32.768 kHz hibernate tick derived from it.
`ifndef HIBERNATE_WAKE_SEQUENCER_DEFS_VH
`define HIBERNATE_WAKE_SEQUENCER_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets.
`define OFS_SLEEP_CTRL 4'h0
`define OFS_WAKE_STATUS 4'h4
`define OFS_RTC_MATCH 4'h8
`define OFS_RTC_COUNT 4'hc

////////////////////////////////////////////////////////////////////////////////
// Sleep control register fields.
`define CTL_REQ 0
`define CTL_OSC_EN 1
`define CTL_RTC_WAKE_EN 2
`define CTL_PIN_WAKE_EN 3
`define CTL_KEPT_ON 4
`define CTL_BOR_EN 5
`define CTL_SLEEPING 31
`define CTL_RESET 6'h00
`define CTL_ISOLATED_VIEW 32'h8000_0000

// Wake status register fields (write one to clear).
`define STS_RTC_MATCH 0
`define STS_PIN_WAKE 1
`define STS_ROUSE_IRQ 2
`define STS_WAKE_LOST 3
`define STS_RESET 4'h0

////////////////////////////////////////////////////////////////////////////////
// Timing.
`define CLK_HZ 10000000
`define SLOW_CLK_HZ 32768
`define SLOW_DIV (`CLK_HZ / `SLOW_CLK_HZ)
`define ENTRY_TICKS 3
`define LEAD_US 31
`define LEAD_CYC ((`LEAD_US * `CLK_HZ) / 1000000)
`define SUPPLY_STABLE_TICKS 3

`endif

// file: hws_props.sv
// Port checker for the hibernate wake sequencer.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module hws_props (
   // Clock and reset.
   input wire clk,
   input wire rst_n,
   // Register port.
   input wire [3:0] addr,
   input wire [31:0] wr_data,
   input wire wr_stb,
   input wire rd_stb,
   input wire [31:0] rd_data,
   // Pins and supply monitors.
   input wire rouse_pin,
   input wire supply_above_por,
   input wire supply_above_bor,
   input wire supply_off_output,
   input wire core_isolate
);
   // Cycles spent isolated with the supply still on.
   reg [15:0] iso_cnt_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////
   // The count clears whenever isolation ends or supply-off is raised.
   always @(posedge clk) begin
      if (!rst_n || !core_isolate || supply_off_output)
         iso_cnt_q <= 16'h0000;
      else
         iso_cnt_q <= iso_cnt_q + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   a_reset_quiet: assert property (disable iff (1'b0)
      !rst_n |=> !supply_off_output && !core_isolate && rd_data == 32'h0000_0000)
      else $error("outputs not cleared by reset");
   a_read_idle: assert property (!rd_stb |=> rd_data == 32'h0000_0000)
      else $error("read data outside a read slot");
   a_iso_view: assert property (
      rd_stb && addr == 4'h0 && core_isolate |=> rd_data == 32'h8000_0000)
      else $error("control not isolated view while sleeping");
   a_off_needs_iso: assert property (supply_off_output |-> core_isolate)
      else $error("supply off without isolation");
   a_off_lead: assert property (
      $rose(supply_off_output) |-> iso_cnt_q inside {16'h0000, [16'h0135:16'h0137]})
      else $error("supply off lead time wrong");
   a_release_order: assert property (
      $fell(core_isolate) && $past(rst_n) |-> !supply_off_output)
      else $error("isolation released with supply off");
   a_exit_keeps_iso: assert property (
      $fell(supply_off_output) && $past(rst_n) |-> core_isolate)
      else $error("isolation dropped before supply returned");
   a_release_supply: assert property (
      $fell(core_isolate) && $past(rst_n) |-> supply_above_por)
      else $error("wake finished with supply low");
endmodule

bind hibernate_wake_sequencer hws_props u_hws_props (.clk, .rst_n, .addr, .wr_data, .wr_stb, .rd_stb,
   .rd_data, .rouse_pin, .supply_above_por, .supply_above_bor, .supply_off_output, .core_isolate);

// file: supply_model.sv
// Model of the external core supply regulator.
// Assumes supply-off high turns the supply off unless kept on.
`timescale 1ns/1ps
module supply_model #(
   parameter FALL_CYC = 200,
   parameter RISE_CYC = 100
) (
   // Clock.
   input wire clk,
   // Control from the sequencer and the bench.
   input wire supply_off_output,
   input wire keep_on,
   input wire dip_en,
   // Supply monitor levels.
   output reg supply_above_por,
   output reg supply_above_bor
);
   // Cycles since the supply was switched off or back on.
   integer dn_cnt, up_cnt;
   initial begin
      dn_cnt = 0;
      up_cnt = 0;
      supply_above_por = 1'b1;
      supply_above_bor = 1'b1;
   end
   // Brown-out level falls first; a dip is made only when the bench asks.
   always @(posedge clk) begin
      if (supply_off_output && !keep_on) begin
         up_cnt <= 0;
         dn_cnt <= dn_cnt + 1;
         if (dn_cnt == FALL_CYC / 2) supply_above_bor <= 1'b0;
         if (dn_cnt == FALL_CYC) supply_above_por <= 1'b0;
      end else begin
         dn_cnt <= 0;
         up_cnt <= up_cnt + 1;
         if (up_cnt == RISE_CYC || (dip_en && up_cnt == RISE_CYC + 550)) begin
            supply_above_por <= 1'b1;
            supply_above_bor <= 1'b1;
         end
         if (dip_en && up_cnt == RISE_CYC + 450) supply_above_por <= 1'b0;
      end
   end
endmodule

// file: testbench.sv
// Self-checking bench for the hibernate wake sequencer.
// Assumes the supply model answers the supply-off output.
`timescale 1ns/1ps
module testbench;
   // Drives, observed outputs and bookkeeping.
   reg clk, rst_n, wr_stb, rd_stb, rouse_pin, keep_on, dip_en;
   reg [3:0] addr;
   reg [31:0] wr_data, v, r;
   wire [31:0] rd_data;
   wire supply_above_por, supply_above_bor, supply_off_output, core_isolate;
   // Levels that the bounded wait can watch, indexed by its selector.
   wire [3:0] lv = {supply_above_bor, supply_above_por, core_isolate, supply_off_output};
   integer mismatches, check_count, seed, n, t;
   hibernate_wake_sequencer u_hibernate_wake_sequencer (.clk, .rst_n, .addr, .wr_data, .wr_stb, .rd_stb,
      .rd_data, .rouse_pin, .supply_above_por, .supply_above_bor, .supply_off_output, .core_isolate);
   supply_model u_supply_model (.clk, .supply_off_output, .keep_on, .dip_en, .supply_above_por,
      .supply_above_bor);
   always #50 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // Expected status word: lost flag, rouse interrupt unless a dip, pin, rtc.
   function [31:0] sts(input lost, input pin, input dip, input rtc);
      sts = {28'h000_0000, lost, pin & ~dip, pin, rtc};
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wr_data <= d;
         wr_stb <= 1'b1;
         @(posedge clk);
         wr_stb <= 1'b0;
      end
   endtask
   // Read data are taken in the single cycle after the strobe.
   task rdv(input [3:0] a);
      begin
         @(posedge clk);
         addr <= a;
         rd_stb <= 1'b1;
         @(posedge clk);
         rd_stb <= 1'b0;
         #1 v = rd_data;
      end
   endtask
   task rd(input [3:0] a, input [31:0] e);
      begin
         rdv(a);
         chk(v, e);
      end
   endtask
   // Bounded wait on supply-off (0), isolation (1), power-on level (2) or brown-out level (3).
   task wt(input integer sel, input val);
      begin
         n = 0;
         while (n < 9000 && lv[sel] !== val) begin
            @(posedge clk);
            #1 n = n + 1;
         end
         chk({31'h0000_0000, n < 9000}, 32'h0000_0001);
      end
   endtask
   task pulse;
      begin
         @(posedge clk);
         rouse_pin <= 1'b1;
         repeat (10) @(posedge clk);
         rouse_pin <= 1'b0;
      end
   endtask
   // Full sleep and pin wake once the supply has gone.
   task sleep_cycle;
      begin
         wt(0, 1'b1);
         wt(2, 1'b0);
         pulse;
         wt(0, 1'b0);
         wt(1, 1'b0);
      end
   endtask
   task fin(input [31:0] e);
      begin
         rd(4'h4, e);
         wr(4'h4, 32'h0000_000f);
         $display("test %0d done", t);
         t = t + 1;
      end
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", check_count, mismatches);
         if (mismatches == 0 && check_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog well beyond the expected run length.
   initial begin
      repeat (60000) @(posedge clk);
      mismatches = mismatches + 1;
      close_out;
   end
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {wr_stb, rd_stb, rouse_pin, keep_on, dip_en} = 5'h00;
      addr = 4'h0;
      wr_data = 32'h0000_0000;
      {mismatches, check_count, n} = 96'h0;
      t = 1;
      seed = 42;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values, an unmapped place and a random match value.
      rd(4'h0, 32'h0000_0000);
      rd(4'h8, 32'hffff_ffff);
      wr(4'h1, 32'hffff_ffff);
      rd(4'h1, 32'h0000_0000);
      r = $random(seed);
      wr(4'h8, r);
      rd(4'h8, r);
      fin(32'h0000_0000);
      // Plain sleep: poll oscillator bit, isolated view, pin wake.
      wr(4'h0, 32'h0000_000b);
      v = 32'h0000_0002;
      for (n = 0; n < 600 && v[1] !== 1'b0; n = n + 1) rdv(4'h0);
      rd(4'h0, 32'h8000_0000);
      sleep_cycle;
      fin(sts(0, 1, 0, 0));
      // Wake inside the lead window is lost; sleep still completes.
      wr(4'h0, 32'h0000_000b);
      wt(1, 1'b1);
      repeat (100) @(posedge clk);
      pulse;
      sleep_cycle;
      fin(sts(1, 1, 0, 0));
      // Kept-on mode has no lost window after isolation.
      keep_on <= 1'b1;
      wr(4'h0, 32'h0000_001b);
      wt(1, 1'b1);
      repeat (100) @(posedge clk);
      pulse;
      wt(1, 1'b0);
      fin(sts(0, 1, 0, 0));
      keep_on <= 1'b0;
      // Match two counts ahead lands in entry and is dropped.
      wr(4'h8, 32'h0000_0002);
      wr(4'hc, 32'h0000_0000);
      wr(4'h0, 32'h0000_000f);
      sleep_cycle;
      fin(sts(1, 1, 0, 0));
      // Match far enough ahead wakes the device.
      wr(4'hc, 32'h0000_0000);
      wr(4'h8, 32'h0000_0014);
      wr(4'h0, 32'h0000_0007);
      wt(0, 1'b1);
      wt(0, 1'b0);
      wt(1, 1'b0);
      fin(sts(0, 0, 0, 1));
      // Brown-out detect on: a wake once the brown-out level is gone is kept,
      // and a supply dip during exit drops the rouse interrupt only.
      dip_en <= 1'b1;
      wr(4'h0, 32'h0000_002b);
      wt(0, 1'b1);
      wt(3, 1'b0);
      pulse;
      wt(0, 1'b0);
      wt(1, 1'b0);
      fin(sts(0, 1, 1, 0));
      close_out;
   end
endmodule
